//--- rtl/qft_defines.svh
// Purpose: Offsets, field positions and reset values of the flash command-threshold block
// Assumes: 32-bit APB data, 12-bit byte address
// Notes:   Definitions only
`ifndef QFT_DEFINES_SVH
`define QFT_DEFINES_SVH

`define QFT_ADDR_W        12
`define QFT_OFF_THR       12'h000
`define QFT_OFF_CTRL      12'h004
`define QFT_OFF_STAT      12'h008

`define QFT_THR_W         5
`define QFT_RX_THR_LSB    0
`define QFT_RX_THR_MSB    4
`define QFT_TX_THR_LSB    8
`define QFT_TX_THR_MSB    12
`define QFT_THR_RST       5'h00

`define QFT_CTRL_MODE_LSB 0
`define QFT_CTRL_MODE_MSB 1
`define QFT_CTRL_WIDE_BIT 2
`define QFT_MODE_RST      2'h0

`define QFT_STAT_BUSY_BIT 0
`define QFT_STAT_DIR_BIT  1
`define QFT_STAT_ST_LSB   2
`define QFT_STAT_ST_MSB   3
`define QFT_STAT_REM_LSB  8

`define QFT_LANE0         0
`define QFT_LANE1         1
`define QFT_WORD_ZERO     32'h0000_0000

`endif

//--- rtl/qft_pkg.sv
// Purpose: Types shared by the command-threshold block
// Assumes: Nothing beyond the defines header
// Notes:   Sequencer states are Gray coded along the usual path
package qft_pkg;

  typedef enum logic [1:0] {
    QFT_MODE_IDLE = 2'h0,
    QFT_MODE_TX   = 2'h1,
    QFT_MODE_RX   = 2'h2,
    QFT_MODE_BOOT = 2'h3
  } qft_mode_t;

  typedef enum logic [1:0] {
    QFT_ST_IDLE = 2'h0,
    QFT_ST_REQ  = 2'h1,
    QFT_ST_RUN  = 2'h3,
    QFT_ST_DONE = 2'h2
  } qft_state_t;

endpackage

//--- rtl/qft_cfg_if.sv
// Purpose: Configuration and status between register slave and sequencer
// Assumes: One clock domain
// Notes:   No clocking block
`timescale 1ns/1ps
interface qft_cfg_if #(
  parameter int CNT_W = 6
);
  logic [4:0]            tx_thr;
  logic [4:0]            rx_thr;
  qft_pkg::qft_mode_t    mode;
  logic                  wide16;
  logic                  busy;
  logic                  dir_rx;
  qft_pkg::qft_state_t   state;
  logic [CNT_W-1:0]      remaining;

  modport regs (
    output tx_thr,
    output rx_thr,
    output mode,
    output wide16,
    input  busy,
    input  dir_rx,
    input  state,
    input  remaining
  );

  modport core (
    input  tx_thr,
    input  rx_thr,
    input  mode,
    input  wide16,
    output busy,
    output dir_rx,
    output state,
    output remaining
  );
endinterface

//--- rtl/qft_apb_regs.sv
// Purpose: APB slave holding threshold and control registers, reading back status
// Assumes: APB4 master, zero wait states
// Notes:   Read data is captured in the setup cycle so it leaves a flip-flop
`timescale 1ns/1ps
`include "qft_defines.svh"
module qft_apb_regs #(
  parameter int CNT_W = 6
) (
  input  wire logic                   clk_sys_i,   // System clock
  input  wire logic                   rst_n_i,     // Synchronous reset, active low
  input  wire logic [`QFT_ADDR_W-1:0] paddr_i,     // Byte address
  input  wire logic                   psel_i,      // Select
  input  wire logic                   penable_i,   // Access phase
  input  wire logic                   pwrite_i,    // Write direction
  input  wire logic [31:0]            pwdata_i,    // Write data
  input  wire logic [3:0]             pstrb_i,     // Byte lanes
  output logic      [31:0]            prdata_o,    // Read data
  output logic                        pready_o,    // Ready
  output logic                        pslverr_o,   // Unmapped address
  qft_cfg_if.regs                     cfg          // Towards sequencer
);

  logic [4:0]         tx_thr;
  logic [4:0]         rx_thr;
  logic [1:0]         mode;
  logic               wide16;
  logic [31:0]        rdata;
  logic [4:0]         next_tx_thr;
  logic [4:0]         next_rx_thr;
  logic [1:0]         next_mode;
  logic               next_wide16;
  logic [31:0]        next_rdata;
  logic               hit_thr;
  logic               hit_ctrl;
  logic               hit_stat;
  logic               wr_acc;

  assign hit_thr  = (paddr_i == `QFT_OFF_THR);
  assign hit_ctrl = (paddr_i == `QFT_OFF_CTRL);
  assign hit_stat = (paddr_i == `QFT_OFF_STAT);
  assign wr_acc   = psel_i && penable_i && pwrite_i;

  always_comb
  begin
    next_tx_thr = tx_thr;
    next_rx_thr = rx_thr;
    next_mode   = mode;
    next_wide16 = wide16;
    next_rdata  = rdata;
    if (wr_acc && hit_thr)
    begin
      if (pstrb_i[`QFT_LANE0])
        next_rx_thr = pwdata_i[`QFT_RX_THR_MSB:`QFT_RX_THR_LSB];
      if (pstrb_i[`QFT_LANE1])
        next_tx_thr = pwdata_i[`QFT_TX_THR_MSB:`QFT_TX_THR_LSB];
    end
    if (wr_acc && hit_ctrl && pstrb_i[`QFT_LANE0])
    begin
      next_mode   = pwdata_i[`QFT_CTRL_MODE_MSB:`QFT_CTRL_MODE_LSB];
      next_wide16 = pwdata_i[`QFT_CTRL_WIDE_BIT];
    end
    if (psel_i && !penable_i)
    begin
      next_rdata = `QFT_WORD_ZERO;
      if (hit_thr)
      begin
        next_rdata[`QFT_RX_THR_MSB:`QFT_RX_THR_LSB] = rx_thr;
        next_rdata[`QFT_TX_THR_MSB:`QFT_TX_THR_LSB] = tx_thr;
      end
      else if (hit_ctrl)
      begin
        next_rdata[`QFT_CTRL_MODE_MSB:`QFT_CTRL_MODE_LSB] = mode;
        next_rdata[`QFT_CTRL_WIDE_BIT]                    = wide16;
      end
      else if (hit_stat)
      begin
        next_rdata[`QFT_STAT_BUSY_BIT]                = cfg.busy;
        next_rdata[`QFT_STAT_DIR_BIT]                 = cfg.dir_rx;
        next_rdata[`QFT_STAT_ST_MSB:`QFT_STAT_ST_LSB] = cfg.state;
        next_rdata[`QFT_STAT_REM_LSB +: CNT_W]        = cfg.remaining;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tx_thr <= `QFT_THR_RST;
      rx_thr <= `QFT_THR_RST;
      mode   <= `QFT_MODE_RST;
      wide16 <= 1'b0;
      rdata  <= `QFT_WORD_ZERO;
    end
    else
    begin
      tx_thr <= next_tx_thr;
      rx_thr <= next_rx_thr;
      mode   <= next_mode;
      wide16 <= next_wide16;
      rdata  <= next_rdata;
    end
  end

  assign prdata_o   = rdata;
  assign pready_o   = 1'b1;
  assign pslverr_o  = psel_i && penable_i && !(hit_thr || hit_ctrl || hit_stat);
  assign cfg.tx_thr = tx_thr;
  assign cfg.rx_thr = rx_thr;
  assign cfg.mode   = qft_pkg::qft_mode_t'(mode);
  assign cfg.wide16 = wide16;

endmodule

//--- rtl/qft_xfer_counter.sv
// Purpose: Counts bytes of the running flash transfer down to zero
// Assumes: One byte strobe per byte moved by the serial engine
// Notes:   Strobes beyond the programmed length are ignored
`timescale 1ns/1ps
module qft_xfer_counter #(
  parameter int CNT_W = 6
) (
  input  wire logic             clk_sys_i,   // System clock
  input  wire logic             rst_n_i,     // Synchronous reset, active low
  input  wire logic             load_i,      // Start counting a new transfer
  input  wire logic [CNT_W-1:0] len_i,       // Bytes in the new transfer
  input  wire logic             byte_i,      // One byte moved
  output logic      [CNT_W-1:0] remain_o,    // Bytes still to move
  output logic                  done_o       // Transfer complete
);

  logic [CNT_W-1:0] remain;
  logic             active;
  logic [CNT_W-1:0] next_remain;
  logic             next_active;

  always_comb
  begin
    next_remain = remain;
    next_active = active;
    if (load_i)
    begin
      next_remain = len_i;
      next_active = 1'b1;
    end
    else if (active && byte_i && (remain != '0))
      next_remain = remain - CNT_W'(1);
    else if (active && (remain == '0))
      next_active = 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      remain <= '0;
      active <= 1'b0;
    end
    else
    begin
      remain <= next_remain;
      active <= next_active;
    end
  end

  assign remain_o = remain;
  assign done_o   = active && (remain == '0);

endmodule

//--- rtl/qft_threshold_top.sv
// Purpose: Threshold-driven start of transmit and receive transfers to a serial flash
// Assumes: FIFO fill levels come from the FIFOs; a serial engine moves the bytes
// Notes:   One transfer at a time; fill levels are sampled only while idle
`timescale 1ns/1ps
`include "qft_defines.svh"
// Operation
// - Transmit starts once TX FIFO reaches threshold
// - Receive fetches up to receive threshold bytes
// - No receive without room for threshold
// - FIFO reads trigger refill back to threshold
// - Boot mode fetch sized by bus burst
// - Unimplemented threshold bits read zero
// - Transmit threshold bits 12:8, reset zero
module qft_threshold_top #(
  parameter int CNT_W      = 6,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                   clk_sys_i,        // System clock, 25 MHz
  input  wire logic                   rst_n_i,          // Synchronous reset, active low
  input  wire logic [`QFT_ADDR_W-1:0] paddr_i,          // APB byte address
  input  wire logic                   psel_i,           // APB select
  input  wire logic                   penable_i,        // APB access phase
  input  wire logic                   pwrite_i,         // APB write
  input  wire logic [31:0]            pwdata_i,         // APB write data
  input  wire logic [3:0]             pstrb_i,          // APB byte lanes
  output logic      [31:0]            prdata_o,         // APB read data
  output logic                        pready_o,         // APB ready
  output logic                        pslverr_o,        // APB error on unmapped address
  input  wire logic [CNT_W-1:0]       tx_fifo_level_i,  // Bytes in TX FIFO
  input  wire logic [CNT_W-1:0]       rx_fifo_level_i,  // Bytes in RX FIFO
  input  wire logic [CNT_W-1:0]       burst_bytes_i,    // System bus burst size, bytes
  output logic                        xfer_req_o,       // Transfer request to engine
  output logic                        xfer_dir_rx_o,    // 1 receive, 0 transmit
  output logic      [CNT_W-1:0]       xfer_len_o,       // Bytes in requested transfer
  input  wire logic                   xfer_ack_i,       // Engine took the request
  input  wire logic                   xfer_byte_i,      // Engine moved one byte
  output logic      [1:0]             mode_o,           // Command-initiation mode
  output logic                        wide16_o,         // 16-bit lane mode
  output logic                        busy_o            // Transfer pending or running
);

  qft_cfg_if #(.CNT_W(CNT_W)) cfg ();

  localparam logic [CNT_W:0] DEPTH = (CNT_W+1)'(FIFO_DEPTH);

  qft_pkg::qft_state_t state;
  qft_pkg::qft_state_t next_state;
  logic                dir_rx;
  logic                next_dir_rx;
  logic [CNT_W-1:0]    len;
  logic [CNT_W-1:0]    next_len;
  logic [CNT_W-1:0]    rx_target;
  logic [CNT_W:0]      rx_free;
  logic [CNT_W-1:0]    tx_need;
  logic                tx_go;
  logic                rx_go;
  logic                is_rx_mode;
  logic                load;
  logic                cnt_done;
  logic [CNT_W-1:0]    cnt_remain;

  qft_apb_regs #(.CNT_W(CNT_W)) u_regs (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .paddr_i   (paddr_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .pwdata_i  (pwdata_i),
    .pstrb_i   (pstrb_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .cfg       (cfg.regs)
  );

  qft_xfer_counter #(.CNT_W(CNT_W)) u_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .load_i    (load),
    .len_i     (len),
    .byte_i    (xfer_byte_i),
    .remain_o  (cnt_remain),
    .done_o    (cnt_done)
  );

  // Boot/XIP fetches follow the bus burst, not the programmed count
  assign rx_target  = (cfg.mode == qft_pkg::QFT_MODE_BOOT) ? burst_bytes_i
                                                           : CNT_W'(cfg.rx_thr);
  assign is_rx_mode = (cfg.mode == qft_pkg::QFT_MODE_RX) || (cfg.mode == qft_pkg::QFT_MODE_BOOT);
  assign rx_free    = DEPTH - {1'b0, rx_fifo_level_i};
  assign tx_need    = CNT_W'(cfg.tx_thr);

  // A zero threshold starts nothing outside boot mode, so a reset block stays quiet
  assign tx_go = (cfg.mode == qft_pkg::QFT_MODE_TX)
              && (tx_need != '0)
              && (tx_fifo_level_i >= tx_need);

  // Refill whenever reads pulled the level below target; room for the full target is required
  assign rx_go = is_rx_mode
              && (rx_target != '0)
              && (rx_fifo_level_i < rx_target)
              && (rx_free >= {1'b0, rx_target});

  always_comb
  begin
    next_state  = state;
    next_dir_rx = dir_rx;
    next_len    = len;
    case (state)
      qft_pkg::QFT_ST_IDLE:
      begin
        if (tx_go)
        begin
          next_state  = qft_pkg::QFT_ST_REQ;
          next_dir_rx = 1'b0;
          next_len    = tx_need;
        end
        else if (rx_go)
        begin
          next_state  = qft_pkg::QFT_ST_REQ;
          next_dir_rx = 1'b1;
          next_len    = rx_target - rx_fifo_level_i;
        end
      end
      qft_pkg::QFT_ST_REQ:
      begin
        if (xfer_ack_i)
          next_state = qft_pkg::QFT_ST_RUN;
      end
      qft_pkg::QFT_ST_RUN:
      begin
        if (cnt_done)
          next_state = qft_pkg::QFT_ST_DONE;
      end
      // One settling cycle lets the FIFO level reflect the last byte before re-evaluating
      qft_pkg::QFT_ST_DONE:
      begin
        next_state = qft_pkg::QFT_ST_IDLE;
      end
      default:
      begin
        next_state = qft_pkg::QFT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state  <= qft_pkg::QFT_ST_IDLE;
      dir_rx <= 1'b0;
      len    <= '0;
    end
    else
    begin
      state  <= next_state;
      dir_rx <= next_dir_rx;
      len    <= next_len;
    end
  end

  assign load          = (state == qft_pkg::QFT_ST_REQ) && xfer_ack_i;
  assign xfer_req_o    = (state == qft_pkg::QFT_ST_REQ);
  assign xfer_dir_rx_o = dir_rx;
  assign xfer_len_o    = len;
  assign busy_o        = (state != qft_pkg::QFT_ST_IDLE);
  assign mode_o        = cfg.mode;
  assign wide16_o      = cfg.wide16;

  assign cfg.busy      = busy_o;
  assign cfg.dir_rx    = dir_rx;
  assign cfg.state     = state;
  assign cfg.remaining = cnt_remain;

endmodule

//--- sim/qft_flash_eng_model.sv
// Purpose: Serial engine stand-in that takes requests and moves bytes
// Assumes: Request holds until acknowledged
// Notes:   Random ack delay and byte gaps give prompt and slow answers
`timescale 1ns/1ps
module qft_flash_eng_model #(
  parameter int CNT_W = 6
) (
  input  wire logic             clk_sys_i,  // System clock
  input  wire logic             rst_n_i,    // Reset, active low
  input  wire logic             req_i,      // Transfer request
  input  wire logic [CNT_W-1:0] len_i,      // Bytes to move
  output logic                  ack_o,      // Request taken
  output logic                  byte_o      // One byte moved
);
  int n;
  int gap;

  initial
  begin
    ack_o  = 1'b0;
    byte_o = 1'b0;
    forever
    begin
      @(posedge clk_sys_i);
      if (rst_n_i === 1'b1 && req_i === 1'b1)
      begin
        n = len_i;
        repeat ($urandom_range(2, 0)) @(posedge clk_sys_i);
        ack_o <= 1'b1;
        @(posedge clk_sys_i);
        ack_o <= 1'b0;
        repeat (n)
        begin
          byte_o <= 1'b1;
          @(posedge clk_sys_i);
          gap = $urandom_range(2, 0);
          if (gap != 0)
          begin
            byte_o <= 1'b0;
            repeat (gap) @(posedge clk_sys_i);
          end
        end
        byte_o <= 1'b0;
      end
    end
  end
endmodule

//--- sim/qft_threshold_props.sv
// Purpose: Port-level properties of the command-threshold block
// Assumes: Single clock, synchronous active-low reset
// Notes:   Start conditions are judged on the edge before the request rises
`timescale 1ns/1ps
`include "qft_defines.svh"
module qft_threshold_props #(
  parameter int CNT_W      = 6,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                   clk_sys_i,        // Clock
  input wire logic                   rst_n_i,          // Reset
  input wire logic [`QFT_ADDR_W-1:0] paddr_i,          // Address
  input wire logic                   psel_i,           // Select
  input wire logic                   penable_i,        // Access
  input wire logic                   pwrite_i,         // Write
  input wire logic [31:0]            prdata_o,         // Read data
  input wire logic [CNT_W-1:0]       tx_fifo_level_i,  // TX level
  input wire logic [CNT_W-1:0]       rx_fifo_level_i,  // RX level
  input wire logic [CNT_W-1:0]       burst_bytes_i,    // Burst size
  input wire logic                   xfer_req_o,       // Request
  input wire logic                   xfer_dir_rx_o,    // Direction
  input wire logic [CNT_W-1:0]       xfer_len_o,       // Length
  input wire logic                   xfer_ack_i,       // Ack
  input wire logic [1:0]             mode_o,           // Mode
  input wire logic                   busy_o            // Busy
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_tx_at_thr: assert property ($rose(xfer_req_o) && !xfer_dir_rx_o |->
    xfer_len_o != 0 && $past(tx_fifo_level_i) >= xfer_len_o) else $error("tx started below threshold");
  a_dir_by_mode: assert property ($rose(xfer_req_o) |->
    xfer_dir_rx_o == ($past(mode_o) != 2'h1)) else $error("direction does not match mode");
  a_idle_quiet: assert property ($rose(xfer_req_o) |-> $past(mode_o) != 2'h0)
    else $error("transfer started in idle mode");
  a_rx_room: assert property ($rose(xfer_req_o) && xfer_dir_rx_o |->
    FIFO_DEPTH - $past(rx_fifo_level_i) >= $past(rx_fifo_level_i) + xfer_len_o) else $error("rx without room");
  a_boot_burst: assert property ($rose(xfer_req_o) && $past(mode_o) == 2'h3 |->
    $past(rx_fifo_level_i) + xfer_len_o == $past(burst_bytes_i)) else $error("boot fetch not burst sized");
  a_req_holds: assert property (xfer_req_o && !xfer_ack_i |=> xfer_req_o && $stable(xfer_len_o))
    else $error("request dropped before ack");
  a_ack_runs: assert property (xfer_req_o && xfer_ack_i |=> !xfer_req_o && busy_o)
    else $error("ack did not start run");
  a_rsvd_zero: assert property (psel_i && penable_i && !pwrite_i && paddr_i == `QFT_OFF_THR |->
    prdata_o[31:13] == 19'h0 && prdata_o[7:5] == 3'h0) else $error("reserved bits not zero");
endmodule

bind qft_threshold_top qft_threshold_props #(.CNT_W(CNT_W), .FIFO_DEPTH(FIFO_DEPTH)) i_qft_threshold_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .tx_fifo_level_i(tx_fifo_level_i), .rx_fifo_level_i(rx_fifo_level_i),
  .burst_bytes_i(burst_bytes_i), .xfer_req_o(xfer_req_o), .xfer_dir_rx_o(xfer_dir_rx_o),
  .xfer_len_o(xfer_len_o), .xfer_ack_i(xfer_ack_i), .mode_o(mode_o), .busy_o(busy_o));

//--- sim/qft_threshold_top_tb.sv
// Purpose: Self-checking bench for the command-threshold block
// Assumes: Bench owns FIFO levels; engine model answers requests
// Notes:   Levels follow each transfer so the block settles afterwards
`timescale 1ns/1ps
`include "qft_defines.svh"
module qft_threshold_top_tb;
  localparam int DEPTH = 32;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] pwdata    = 32'h0;
  logic [3:0]  pstrb     = 4'hF;
  logic [5:0]  tx_lvl    = 6'h00;
  logic [5:0]  rx_lvl    = 6'h00;
  logic [5:0]  burst     = 6'h00;
  logic [31:0] prdata;
  logic [31:0] rd_v;
  logic [31:0] v;
  logic [5:0]  len;
  logic [1:0]  mode;
  logic        pready, pslverr, req, dir, ack, byte_s, wide, busy, err_v;
  int          n_errors   = 0;
  int          num_checks = 0;
  int          m_mode     = 0;
  int          m_tx       = 0;
  int          m_rx       = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  qft_threshold_top #(.CNT_W(6), .FIFO_DEPTH(DEPTH)) i_qft_threshold_top (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_fifo_level_i(tx_lvl), .rx_fifo_level_i(rx_lvl), .burst_bytes_i(burst),
    .xfer_req_o(req), .xfer_dir_rx_o(dir), .xfer_len_o(len), .xfer_ack_i(ack), .xfer_byte_i(byte_s),
    .mode_o(mode), .wide16_o(wide), .busy_o(busy));

  qft_flash_eng_model #(.CNT_W(6)) i_qft_flash_eng_model (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req), .len_i(len), .ack_o(ack), .byte_o(byte_s));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge clk_sys_i);
    rd_v    = prdata;
    err_v   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (w && a == `QFT_OFF_THR)
    begin
      if (pstrb[1])
        m_tx = d[12:8];
      if (pstrb[0])
        m_rx = d[4:0];
    end
    if (w && a == `QFT_OFF_CTRL && pstrb[0])
      m_mode = d[1:0];
  endtask

  // Reference: length the block should request now, -1 for none
  function automatic int exp_len(output bit d);
    int t;
    d = m_mode >= 2;
    t = (m_mode == 3) ? int'(burst) : m_rx;
    if (m_mode == 1)
      return (m_tx != 0 && tx_lvl >= m_tx) ? m_tx : -1;
    if (d && t != 0 && rx_lvl < t && DEPTH - rx_lvl >= t)
      return t - rx_lvl;
    return -1;
  endfunction

  task automatic lvl(input int t, input int r);
    @(posedge clk_sys_i);
    tx_lvl <= 6'(t);
    rx_lvl <= 6'(r);
    @(posedge clk_sys_i);
  endtask

  // Mode goes idle first so thresholds never change under a receive
  task automatic setup(input int md, input logic [31:0] thr, input int t, input int r, input int b);
    apb(`QFT_OFF_CTRL, 1'b1, 32'h0);
    tx_lvl <= 6'(t);
    rx_lvl <= 6'(r);
    burst  <= 6'(b);
    apb(`QFT_OFF_THR, 1'b1, thr);
    apb(`QFT_OFF_CTRL, 1'b1, 32'(md));
  endtask

  task automatic xfer(input string nm);
    int e;
    int k;
    bit d;
    e = exp_len(d);
    k = 0;
    while (req !== 1'b1 && k++ < 8)
      @(posedge clk_sys_i);
    chk({nm, " req"}, req, 32'(e >= 0));
    if (req === 1'b1)
    begin
      chk({nm, " dir"}, dir, d);
      chk({nm, " len"}, len, e);
      if (d)
        rx_lvl <= rx_lvl + len;
      else
        tx_lvl <= tx_lvl - len;
      k = 0;
      while (busy !== 1'b0 && k++ < 300)
        @(posedge clk_sys_i);
      chk({nm, " end"}, busy, 1'b0);
    end
    $display("test %s done", nm);
  endtask

  initial
  begin
    void'($urandom(65871));
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    apb(`QFT_OFF_THR, 1'b0, 32'h0);
    chk("thr reset", rd_v, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom;
      pstrb <= (i < 2) ? 4'hF : 4'($urandom);
      apb(`QFT_OFF_THR, 1'b1, v);
      pstrb <= 4'hF;
      apb(`QFT_OFF_THR, 1'b0, 32'h0);
      chk("thr read", rd_v, 32'((m_tx << 8) | m_rx));
    end
    apb(`QFT_OFF_THR, 1'b1, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      apb(`QFT_OFF_CTRL, 1'b1, 32'(i));
      apb(`QFT_OFF_CTRL, 1'b0, 32'h0);
      chk("ctrl read", {wide, mode}, 32'(i));
      chk("ctrl rdata", rd_v, 32'(i));
    end
    apb(12'h010, 1'b0, 32'h0);
    chk("unmapped err", err_v, 1'b1);
    chk("unmapped data", rd_v, 32'h0);
    $display("test registers done");
    setup(0, 32'h0000_0408, 31, 0, 8);
    xfer("idle mode");
    setup(1, 32'h0000_0400, 3, 0, 0);
    xfer("tx below");
    lvl(4, 0);
    xfer("tx at thr");
    for (int i = 0; i < 3; i++)
    begin
      v = 1 + $urandom_range(30);
      setup(1, v << 8, v, 0, 0);
      xfer("tx random");
    end
    setup(1, 32'h0000_0100, 1, 0, 0);
    xfer("tx one");
    setup(5, 32'h0000_0600, 7, 0, 0);
    xfer("tx wide");
    chk("wide16", wide, 1'b1);
    setup(2, 32'h0000_000A, 0, 4, 0);
    xfer("rx fill");
    xfer("rx full");
    apb(`QFT_OFF_CTRL, 1'b1, 32'h0);
    lvl(0, 7);
    xfer("rx idle read");
    apb(`QFT_OFF_CTRL, 1'b1, 32'h2);
    xfer("rx refill");
    setup(2, 32'h0000_0014, 0, 15, 0);
    xfer("rx no room");
    lvl(0, 12);
    xfer("rx room");
    setup(3, 32'h0000_0014, 0, 2, 8);
    xfer("boot burst");
    // Idle after a receive: not busy, direction still receive, nothing left
    apb(`QFT_OFF_STAT, 1'b0, 32'h0);
    chk("status idle", rd_v, 32'h0000_0002);
    $display("test status done");
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    wrap_up();
  end
endmodule
